// File: src/adc_host_defines.svh
`ifndef ADC_HOST_DEFINES_SVH
`define ADC_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 25
// Least waits round up, never below one cycle
`define CYC_MIN(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define T_CNCS_NS 10
`define T_CSCN_NS 10
`define T_CSCK_NS 8
`define T_CKCS_NS 10
`define T_PH_CN_NS 25
`define T_PL_RD_NS 15
`define T_PH_RD_NS 15
`define T_PH_RST_NS 50
`define T_STBYCN_US 100
`define T_RSTCN_US 25
`define T_SDRST_INT_MS 50
`define T_SDRST_EXT_MS 13
`define SYNC_LAT 3

`define ADDR_CTRL 4'h0
`define ADDR_CMD 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_DATA 4'h3

`define CTRL_MODE_LSB 0
`define CTRL_OS_LSB 2
`define CTRL_EXT_REF 5
`define CTRL_DURING 6
`define CMD_START 0
`define CMD_STANDBY_CONTROL_N_ENTER 1
`define CMD_STANDBY_CONTROL_N_EXIT 2
`define CMD_SD_EXIT 3
`define CMD_RESET 4
`define ST_BUSY 0
`define ST_ACTIVE 1
`define ST_FIFO_VALID 2
`define ST_OVERLAP 3
`define ST_REFUSED 4
`define ST_POWER_OK 5

`define CHANNELS 6
`define SER_WORDS_PER_LINE 3
`endif

// File: src/adc_host_pkg.sv
package adc_host_pkg;
	typedef enum logic [1:0] {
		MODE_PAR = 2'b00,
		MODE_BYTE = 2'b01,
		MODE_SER = 2'b10
	} mode_type;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_STANDBY_CONTROL_N_WAIT = 4'b0001,
		S_SD_WAIT = 4'b0010,
		S_RST_HIGH = 4'b0011,
		S_RST_WAIT = 4'b0100,
		S_CONV = 4'b0101,
		S_CNCS_WAIT = 4'b0110,
		S_BUSY_RISE = 4'b0111,
		S_BUSY_FALL = 4'b1000,
		S_RD_LOW = 4'b1001,
		S_RD_HIGH = 4'b1010,
		S_SCK_LOW = 4'b1011,
		S_SCK_HIGH = 4'b1100,
		S_PUSH = 4'b1101,
		S_CS_HOLD = 4'b1110,
		S_FINISH = 4'b1111
	} state_type;
endpackage : adc_host_pkg

// File: src/adc_host.sv
// Summary of operation
// - chip select waits 10 ns after start edge
// - during-conversion read ends 40 ns before busy falls (not timed here; a busy fall mid-read only sets the overlap flag)
// - after-conversion read starts after busy falls
// - read ends 10 ns before next start edge
// - chip select falls no later than read strobe
// - chip select rises no earlier than read strobe
// - chip select leads first serial edge by 8 ns
// - chip select held 10 ns after last edge
// - ratio select stable around busy falling edge
// - wait 100 us after standby exit
// - refuse starts until exit waits complete
// - wait 50 or 13 ms before reset
// - reset pulse high at least 50 ns
// - wait 25 us after reset before start
// - second start strobe within 500 us
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "adc_host_defines.svh"

module sample_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sample_fifo

module adc_host #(
	parameter int SDRST_INT_CYC = `CYC_MIN(`T_SDRST_INT_MS * 1000000),
	parameter int SDRST_EXT_CYC = `CYC_MIN(`T_SDRST_EXT_MS * 1000000),
	parameter int SCLK_HALF_CYC = 4,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	output logic sample_start_group_a,
	output logic sample_start_group_b,
	output logic cs_n,
	output logic rd_n,
	output logic sclk,
	output logic [2:0] oversample_ratio_select,
	output logic standby_control_n,
	output logic dev_reset,
	input wire logic busy,
	input wire logic [15:0] parallel_result_bus,
	input wire logic serial_out_first,
	input wire logic serial_out_second,
	input wire logic first_channel_flag
);
	import adc_host_pkg::*;

	localparam int CNCS_CYC = `CYC_MIN(`T_CNCS_NS);
	localparam int CSCN_CYC = `CYC_MIN(`T_CSCN_NS);
	localparam int CSCK_CYC = `CYC_MIN(`T_CSCK_NS);
	localparam int CKCS_CYC = `CYC_MIN(`T_CKCS_NS);
	localparam int CONV_HIGH_CYC = `CYC_MIN(`T_PH_CN_NS);
	localparam int RD_LOW_CYC = `CYC_MIN(`T_PL_RD_NS) + `SYNC_LAT;
	localparam int RD_HIGH_CYC = `CYC_MIN(`T_PH_RD_NS);
	localparam int RST_HIGH_CYC = `CYC_MIN(`T_PH_RST_NS);
	localparam int STBYCN_CYC = `CYC_MIN(`T_STBYCN_US * 1000);
	localparam int RSTCN_CYC = `CYC_MIN(`T_RSTCN_US * 1000);
	localparam int SCK_SETUP_CYC = (CSCK_CYC > SCLK_HALF_CYC) ? CSCK_CYC : SCLK_HALF_CYC;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [19:0] sync1_reg;
	logic [19:0] sync2_reg;
	logic busy_d_reg;
	logic busy_s;
	logic [15:0] bus_s;
	logic ser_a_s;
	logic ser_b_s;
	logic flag_s;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			busy_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {busy, parallel_result_bus, serial_out_first, serial_out_second, first_channel_flag};
			sync2_reg <= sync1_reg;
			busy_d_reg <= sync2_reg[19];
		end
	end
	assign busy_s = sync2_reg[19];
	assign bus_s = sync2_reg[18:3];
	assign ser_a_s = sync2_reg[2];
	assign ser_b_s = sync2_reg[1];
	assign flag_s = sync2_reg[0];

	// ************************************************************
	// Control registers
	// ************************************************************
	logic [6:0] ctrl_reg;
	logic overlap_reg;
	logic refused_reg;
	logic power_ok_reg;
	state_type state_reg;
	logic cmd_wr;
	logic [4:0] cmd;
	mode_type mode;
	logic during;
	logic cmd_ok;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [16:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [16:0] fifo_out_data;
	logic reading;

	assign cmd_wr = wr_stb && (addr == `ADDR_CMD);
	assign cmd = wdata[4:0];
	assign mode = mode_type'(ctrl_reg[`CTRL_MODE_LSB +: 2]);
	// Serial reads are too long to fit inside a conversion, so they always go after it
	assign during = ctrl_reg[`CTRL_DURING] && (mode != MODE_SER);
	assign cmd_ok = (state_reg == S_IDLE);
	assign fifo_out_ready = rd_stb && (addr == `ADDR_DATA);
	assign reading = (state_reg == S_RD_LOW) || (state_reg == S_RD_HIGH) || (state_reg == S_PUSH);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= '0;
		end else if (wr_stb && (addr == `ADDR_CTRL)) begin
			ctrl_reg <= wdata[6:0];
		end
	end

	// Sticky flags: a new event in the clearing cycle wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			overlap_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			if (wr_stb && (addr == `ADDR_STATUS) && wdata[`ST_OVERLAP]) begin
				overlap_reg <= 1'b0;
			end
			if (wr_stb && (addr == `ADDR_STATUS) && wdata[`ST_REFUSED]) begin
				refused_reg <= 1'b0;
			end
			if (reading && during && busy_d_reg && !busy_s) begin
				overlap_reg <= 1'b1;
			end
			if (cmd_wr && (cmd != '0) && (!cmd_ok || (cmd[`CMD_START] && (!power_ok_reg || busy_s)))) begin
				refused_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (rd_stb) begin
			case (addr)
				`ADDR_CTRL: rdata <= {25'h0, ctrl_reg};
				`ADDR_STATUS: rdata <= {26'h0, power_ok_reg, refused_reg, overlap_reg, fifo_out_valid,
					(state_reg != S_IDLE), busy_s};
				`ADDR_DATA: rdata <= fifo_out_valid ? {15'h0, fifo_out_data} : 32'h0;
				default: rdata <= 32'h0;
			endcase
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	logic [20:0] timer_reg;
	logic [3:0] word_reg;
	logic [3:0] bit_reg;
	logic second_reg;
	logic [7:0] hi_byte_reg;
	logic [15:0] sh_a_reg;
	logic [15:0] sh_b_reg;
	logic word_flag_reg;
	logic [3:0] last_word;
	logic t_done;

	assign last_word = (mode == MODE_BYTE) ? 4'(2 * `CHANNELS - 1) :
		(mode == MODE_SER) ? 4'(`SER_WORDS_PER_LINE - 1) : 4'(`CHANNELS - 1);
	assign fifo_in_valid = (state_reg == S_PUSH);
	assign fifo_in_data = second_reg ? {1'b0, sh_b_reg} : {word_flag_reg, sh_a_reg};

	function automatic logic reached(input logic [20:0] t, input int n);
		reached = (t >= 21'(n - 1));
	endfunction : reached

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= S_IDLE;
			timer_reg <= '0;
			word_reg <= '0;
			bit_reg <= '0;
			second_reg <= 1'b0;
			hi_byte_reg <= '0;
			sh_a_reg <= '0;
			sh_b_reg <= '0;
			word_flag_reg <= 1'b0;
			power_ok_reg <= 1'b0;
			sample_start_group_a <= 1'b0;
			sample_start_group_b <= 1'b0;
			cs_n <= 1'b1;
			rd_n <= 1'b1;
			sclk <= 1'b0;
			oversample_ratio_select <= '0;
			standby_control_n <= 1'b1;
			dev_reset <= 1'b0;
		end else begin
			timer_reg <= timer_reg + 21'h1;
			case (state_reg)
				S_IDLE: begin
					timer_reg <= '0;
					if (cmd_wr) begin
						if (cmd[`CMD_START] && power_ok_reg && !busy_s) begin
							// Ratio pins only move here, well clear of any busy edge
							oversample_ratio_select <= ctrl_reg[`CTRL_OS_LSB +: 3];
							sample_start_group_a <= 1'b1;
							sample_start_group_b <= 1'b1;
							state_reg <= S_CONV;
						end else if (cmd[`CMD_STANDBY_CONTROL_N_ENTER]) begin
							standby_control_n <= 1'b0;
							power_ok_reg <= 1'b0;
						end else if (cmd[`CMD_STANDBY_CONTROL_N_EXIT]) begin
							standby_control_n <= 1'b1;
							power_ok_reg <= 1'b0;
							state_reg <= S_STANDBY_CONTROL_N_WAIT;
						end else if (cmd[`CMD_SD_EXIT]) begin
							standby_control_n <= 1'b1;
							power_ok_reg <= 1'b0;
							state_reg <= S_SD_WAIT;
						end else if (cmd[`CMD_RESET]) begin
							dev_reset <= 1'b1;
							power_ok_reg <= 1'b0;
							state_reg <= S_RST_HIGH;
						end
					end
				end
				S_STANDBY_CONTROL_N_WAIT: begin
					if (reached(timer_reg, STBYCN_CYC)) begin
						power_ok_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				S_SD_WAIT: begin
					if (reached(timer_reg, ctrl_reg[`CTRL_EXT_REF] ? SDRST_EXT_CYC : SDRST_INT_CYC)) begin
						dev_reset <= 1'b1;
						timer_reg <= '0;
						state_reg <= S_RST_HIGH;
					end
				end
				S_RST_HIGH: begin
					if (reached(timer_reg, RST_HIGH_CYC)) begin
						dev_reset <= 1'b0;
						timer_reg <= '0;
						state_reg <= S_RST_WAIT;
					end
				end
				S_RST_WAIT: begin
					if (reached(timer_reg, RSTCN_CYC)) begin
						power_ok_reg <= 1'b1;
						state_reg <= S_IDLE;
					end
				end
				S_CONV: begin
					if (reached(timer_reg, CONV_HIGH_CYC)) begin
						sample_start_group_a <= 1'b0;
						sample_start_group_b <= 1'b0;
						timer_reg <= '0;
						state_reg <= during ? S_CNCS_WAIT : S_BUSY_RISE;
					end
				end
				S_CNCS_WAIT: begin
					// Strobe stayed high CONV_HIGH_CYC already; this adds the select delay on top
					if (reached(timer_reg, CNCS_CYC)) begin
						cs_n <= 1'b0;
						word_reg <= '0;
						timer_reg <= '0;
						state_reg <= S_RD_LOW;
					end
				end
				S_BUSY_RISE: begin
					if (busy_s) begin
						state_reg <= S_BUSY_FALL;
					end
				end
				S_BUSY_FALL: begin
					timer_reg <= '0;
					if (!busy_s) begin
						cs_n <= 1'b0;
						word_reg <= '0;
						bit_reg <= '0;
						state_reg <= (mode == MODE_SER) ? S_SCK_LOW : S_RD_LOW;
					end
				end
				S_RD_LOW: begin
					rd_n <= 1'b0;
					if (reached(timer_reg, RD_LOW_CYC)) begin
						rd_n <= 1'b1;
						timer_reg <= '0;
						if (mode == MODE_BYTE && !word_reg[0]) begin
							hi_byte_reg <= bus_s[7:0];
							word_flag_reg <= flag_s;
							state_reg <= S_RD_HIGH;
						end else begin
							sh_a_reg <= (mode == MODE_BYTE) ? {hi_byte_reg, bus_s[7:0]} : bus_s;
							if (mode != MODE_BYTE) begin
								word_flag_reg <= flag_s;
							end
							second_reg <= 1'b0;
							state_reg <= S_PUSH;
						end
					end
				end
				S_PUSH: begin
					// Full FIFO holds the read here until software drains it
					timer_reg <= '0;
					if (fifo_in_ready) begin
						if (mode == MODE_SER && !second_reg) begin
							second_reg <= 1'b1;
						end else if (mode == MODE_SER) begin
							word_reg <= word_reg + 4'h1;
							state_reg <= (word_reg == last_word) ? S_CS_HOLD : S_SCK_LOW;
						end else begin
							state_reg <= S_RD_HIGH;
						end
					end
				end
				S_RD_HIGH: begin
					if (reached(timer_reg, RD_HIGH_CYC)) begin
						timer_reg <= '0;
						word_reg <= word_reg + 4'h1;
						state_reg <= (word_reg == last_word) ? S_CS_HOLD : S_RD_LOW;
					end
				end
				S_SCK_LOW: begin
					if (reached(timer_reg, (bit_reg == 4'h0 && word_reg == 4'h0) ? SCK_SETUP_CYC : SCLK_HALF_CYC)) begin
						sh_a_reg <= {sh_a_reg[14:0], ser_a_s};
						sh_b_reg <= {sh_b_reg[14:0], ser_b_s};
						if (bit_reg == 4'h0) begin
							word_flag_reg <= flag_s;
						end
						sclk <= 1'b1;
						timer_reg <= '0;
						state_reg <= S_SCK_HIGH;
					end
				end
				S_SCK_HIGH: begin
					if (reached(timer_reg, SCLK_HALF_CYC)) begin
						sclk <= 1'b0;
						timer_reg <= '0;
						bit_reg <= bit_reg + 4'h1;
						second_reg <= 1'b0;
						state_reg <= (bit_reg == 4'hf) ? S_PUSH : S_SCK_LOW;
					end
				end
				S_CS_HOLD: begin
					if (reached(timer_reg, CKCS_CYC)) begin
						cs_n <= 1'b1;
						timer_reg <= '0;
						state_reg <= S_FINISH;
					end
				end
				S_FINISH: begin
					if (busy_s) begin
						timer_reg <= '0;
					end else if (reached(timer_reg, CSCN_CYC)) begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	sample_fifo #(
		.WIDTH(17),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);
endmodule : adc_host

// File: test/adc_host_sva.sv
`timescale 1ns/10ps
module adc_host_sva #(
	parameter int SDRST_EXT_CYC = 4
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sample_start_group_a,
	input wire logic sample_start_group_b,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic sclk,
	input wire logic [2:0] oversample_ratio_select,
	input wire logic standby_control_n,
	input wire logic dev_reset,
	input wire logic busy
);
	logic [15:0] since_rst;
	logic [15:0] since_standby_control_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Saturating at all ones also stands for never seen since reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			since_rst <= 16'hffff;
		end else if (dev_reset) begin
			since_rst <= 16'h0;
		end else if (since_rst != 16'hffff) begin
			since_rst <= since_rst + 16'h1;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			since_standby_control_n <= 16'hffff;
		end else if (!standby_control_n) begin
			since_standby_control_n <= 16'h0;
		end else if (since_standby_control_n != 16'hffff) begin
			since_standby_control_n <= since_standby_control_n + 16'h1;
		end
	end
	sequence cs_quiet;
		cs_n ##1 cs_n;
	endsequence
	sequence rd_pulse;
		!rd_n [*3] ##1 rd_n;
	endsequence
	a_strobe_pair: assert property (sample_start_group_a == sample_start_group_b)
		else $error("start strobes differ");
	a_start_cs_clear: assert property ($rose(sample_start_group_a) |-> !$past(cs_n) == 1'b0 ##0 cs_quiet)
		else $error("chip select low near start");
	a_cs_busy_order: assert property ($fell(cs_n) |-> !busy || $past(sample_start_group_a, 2)
		|| $past(sample_start_group_a, 3))
		else $error("chip select fell while busy");
	a_read_pulse: assert property ($fell(rd_n) |-> rd_pulse)
		else $error("read strobe width wrong");
	a_cs_rd_setup: assert property ($fell(rd_n) |-> !cs_n && !$past(cs_n))
		else $error("read strobe before chip select");
	a_cs_rd_hold: assert property ($rose(cs_n) |-> $past(rd_n))
		else $error("chip select released before read strobe");
	a_sclk_lead: assert property ($rose(sclk) |-> !cs_n && !$past(cs_n, 3))
		else $error("serial clock too soon after chip select");
	a_cs_sclk_hold: assert property ($rose(cs_n) |-> !$past(sclk))
		else $error("chip select released too soon after clock");
	a_ratio_stable: assert property ($fell(busy) |-> $stable(oversample_ratio_select) ##1
		$stable(oversample_ratio_select))
		else $error("ratio select moved at busy fall");
	a_standby_control_n_start_gap: assert property ($rose(sample_start_group_a) |-> since_standby_control_n >= 16'd4000)
		else $error("start too soon after standby exit");
	a_sd_reset_gap: assert property ($rose(dev_reset) |-> since_standby_control_n >= 16'(SDRST_EXT_CYC))
		else $error("reset too soon after shutdown exit");
	a_reset_pulse: assert property ($rose(dev_reset) |-> dev_reset [*2])
		else $error("device reset pulse too short");
	a_reset_start_gap: assert property ($rose(sample_start_group_a) |-> since_rst >= 16'd1000)
		else $error("start too soon after device reset");
endmodule : adc_host_sva

// File: test/adc_device_model.sv
`timescale 1ns/10ps
module adc_device_model #(
	parameter int CONV_CYC = 60
) (
	input wire logic clk,
	input wire logic start_a,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic sclk,
	input wire logic [2:0] os,
	input wire logic [1:0] mode,
	input wire logic [15:0] pat,
	output logic busy,
	output logic [15:0] bus,
	output logic dout_a,
	output logic dout_b,
	output logic first_flag
);
	logic [15:0] res [6];
	logic [15:0] cnt = 16'h0;
	logic [15:0] word;
	logic start_q = 1'b0;
	logic tog = 1'b0;
	int idx = 0;
	int bits = 0;
	initial busy = 1'b0;
	always @(posedge clk) begin
		start_q <= start_a;
		tog <= ~tog;
		if (start_a && !start_q && !busy) begin
			busy <= 1'b1;
			cnt <= 16'(CONV_CYC << os);
		end else if (busy) begin
			cnt <= cnt - 16'h1;
			if (cnt == 16'h1) begin
				busy <= 1'b0;
				for (int c = 0; c < 6; c++) res[c] <= pat + 16'(c) * 16'h1111;
			end
		end
	end
	always @(negedge cs_n) begin
		idx = 0;
		bits = 0;
	end
	always @(posedge rd_n) idx = idx + 1;
	always @(posedge sclk) bits = bits + 1;
	assign word = res[(mode == 2'b01 ? idx / 2 : idx) % 6];
	// Released lines toggle every cycle so a late sample cannot match by luck
	assign bus = (!cs_n && !rd_n) ? (mode == 2'b01 ? {{8{tog}}, idx[0] ? word[7:0] : word[15:8]} : word) : {16{tog}};
	assign dout_a = (!cs_n && bits < 48) ? res[bits / 16][15 - bits % 16] : tog;
	assign dout_b = (!cs_n && bits < 48) ? res[bits / 16 + 3][15 - bits % 16] : ~tog;
	assign first_flag = !cs_n ? (mode == 2'b10 ? bits < 16 : (mode == 2'b01 ? idx / 2 : idx) == 0) : tog;
endmodule : adc_device_model

// File: test/testbench.sv
`timescale 1ns/10ps
module testbench;
	import adc_host_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [31:0] rdata;
	logic st_a, st_b, cs_n, rd_n, sclk, standby_control_n_n, dev_rst, busy, dout_a, dout_b, flag;
	logic [2:0] os;
	logic [15:0] bus;
	logic [15:0] pat = 16'h0;
	logic [15:0] b0;
	logic [1:0] dmode = 2'b00;
	logic rd_q = 1'b0;
	logic [31:0] last_rd;
	logic [63:0] note;
	logic [63:0] notes [$];
	int failures = 0;
	int tests_run = 0;
	always #12.5 clk = ~clk;
	adc_host #(.SDRST_INT_CYC(4200), .SDRST_EXT_CYC(4000)) u_adc_host (.clk(clk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sample_start_group_a(st_a),
		.sample_start_group_b(st_b), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk), .oversample_ratio_select(os),
		.standby_control_n(standby_control_n_n), .dev_reset(dev_rst), .busy(busy), .parallel_result_bus(bus),
		.serial_out_first(dout_a), .serial_out_second(dout_b), .first_channel_flag(flag));
	adc_device_model u_adc_device_model (.clk(clk), .start_a(st_a), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk),
		.os(os), .mode(dmode), .pat(pat), .busy(busy), .bus(bus), .dout_a(dout_a), .dout_b(dout_b),
		.first_flag(flag));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// ***************
	// Register port
	// ***************
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask);
		notes.push_back({exp & mask, mask});
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask : rd
	always @(posedge clk) begin
		rd_q <= rd_stb;
		if (rd_q) begin
			last_rd = rdata;
			note = notes.pop_front();
			if (note[31:0] != 32'h0) begin
				chk("rdata", note[63:32], rdata & note[31:0]);
			end
		end
	end
	task automatic idle(input int limit);
		int n = 0;
		do begin
			rd(4'h2, 32'h0, 32'h0);
			repeat (2) @(posedge clk);
			n++;
		end while (last_rd[1] !== 1'b0 && n < limit);
		chk("sequencer idle", 32'h0, {31'h0, last_rd[1]});
	endtask : idle
	task automatic drain(input mode_type m, input logic [15:0] x0, input logic [15:0] x1, input int k0, input int k1);
		int c;
		for (int k = k0; k < k1; k++) begin
			c = (m == MODE_SER) ? (k % 6 % 2) * 3 + k % 6 / 2 : k % 6;
			rd(4'h3, {15'h0, m != MODE_SER && c == 0, (k < 6 ? x0 : x1) + 16'(c) * 16'h1111},
				m == MODE_SER ? 32'hffff : 32'h1ffff);
		end
	endtask : drain
	task automatic conv(input mode_type m, input logic during, input logic [2:0] r);
		logic [15:0] base;
		base = pat;
		pat <= 16'($urandom);
		dmode <= m;
		wr(4'h0, {25'h0, during, 1'b0, r, m});
		wr(4'h1, 32'h1);
		idle(300);
		if (!during) begin
			base = pat;
		end
		drain(m, base, base, 0, 6);
		rd(4'h2, 32'h0, 32'h8);
	endtask : conv
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	// Whole run needs about 13000 cycles; this is well beyond it
	initial begin
		#1000000;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(32'hf5f8));
		repeat (16) @(posedge clk);
		chk("idle pins", 32'hc2, {23'h0, st_a, st_b, cs_n, rd_n, sclk, os, standby_control_n_n, dev_rst});
		nrst <= 1'b1;
		wr(4'h0, 32'h5a);
		rd(4'h0, 32'h5a, 32'h7f);
		wr(4'h5, 32'hffffffff);
		rd(4'h5, 32'h0, 32'hffffffff);
		rd(4'h0, 32'h5a, 32'h7f);
		wr(4'h1, 32'h1);
		rd(4'h2, 32'h10, 32'h32);
		wr(4'h2, 32'h10);
		wr(4'h1, 32'h10);
		idle(600);
		rd(4'h2, 32'h20, 32'h30);
		conv(MODE_PAR, 1'b0, 3'($urandom_range(2, 0)));
		conv(MODE_BYTE, 1'b0, 3'($urandom_range(2, 0)));
		conv(MODE_SER, 1'b0, 3'($urandom_range(2, 0)));
		conv(MODE_PAR, 1'b1, 3'h1);
		conv(MODE_BYTE, 1'b1, 3'h1);
		conv(MODE_PAR, 1'b0, 3'h0);
		// Second start is refused mid-burst; a later burst then overfills the FIFO and stalls
		pat <= 16'($urandom);
		wr(4'h1, 32'h1);
		wr(4'h1, 32'h1);
		idle(300);
		b0 = pat;
		pat <= 16'($urandom);
		wr(4'h1, 32'h1);
		repeat (400) @(posedge clk);
		rd(4'h2, 32'h16, 32'h16);
		drain(MODE_PAR, b0, pat, 0, 8);
		idle(300);
		drain(MODE_PAR, b0, pat, 8, 12);
		wr(4'h2, 32'h10);
		wr(4'h1, 32'h2);
		repeat (3) @(posedge clk);
		chk("standby pin", 32'h0, {31'h0, standby_control_n_n});
		wr(4'h1, 32'h4);
		idle(1200);
		chk("standby pin", 32'h1, {31'h0, standby_control_n_n});
		conv(MODE_PAR, 1'b0, 3'h2);
		wr(4'h1, 32'h2);
		wr(4'h1, 32'h8);
		idle(1600);
		conv(MODE_SER, 1'b0, 3'h0);
		conclude();
	end
endmodule : testbench
bind adc_host adc_host_sva #(.SDRST_EXT_CYC(SDRST_EXT_CYC)) u_adc_host_sva (.clk(clk), .nrst(nrst),
	.sample_start_group_a(sample_start_group_a), .sample_start_group_b(sample_start_group_b), .cs_n(cs_n),
	.rd_n(rd_n), .sclk(sclk), .oversample_ratio_select(oversample_ratio_select),
	.standby_control_n(standby_control_n), .dev_reset(dev_reset), .busy(busy));
